// *** ltirq_pkg.sv ***
// constants and types shared by the light threshold interrupt reporting block
package ltirq_pkg;

	// ****************************************
	// register bus geometry and offsets
	// ****************************************
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_RESULT = 4'h0;
	localparam logic [3:0] ADDR_CFG = 4'h1;
	localparam logic [3:0] ADDR_LOW = 4'h2;
	localparam logic [3:0] ADDR_HIGH = 4'h3;
	localparam logic [3:0] ADDR_STAT = 4'h4;

	// ****************************************
	// configuration field positions
	// ****************************************
	localparam int CFG_FC_LSB = 0;
	localparam int CFG_LEVEL = 3;
	localparam int CFG_LATCH = 4;
	localparam int CFG_FLAG_LOW = 5;
	localparam int CFG_FLAG_HIGH = 6;
	localparam int CFG_READY = 7;
	localparam int CFG_MODE_LSB = 9;
	localparam int LOW_TOP_LSB = 14;
	localparam int STAT_PIN = 0;
	localparam int STAT_ACTIVE = 1;

	// ****************************************
	// codes and reset values
	// ****************************************
	localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
	localparam logic [1:0] EOC_CODE = 2'h3;
	localparam logic [15:0] LOW_RST = 16'h0000;
	localparam logic [15:0] HIGH_RST = 16'hffff;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic LATCH_RST = 1'h1;
	localparam logic LEVEL_RST = 1'h0;
	localparam logic [1:0] FC_RST = 2'h0;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [2:0] RUN_SAT = 3'h4;

	// one bus request: address, write data and the two strobes
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} ltirq_req_type;

	// outcome of one conversion against the two limits
	typedef enum logic [1:0] {
		LTIRQ_CMP_NONE = 2'b00,
		LTIRQ_CMP_HIGH = 2'b01,
		LTIRQ_CMP_LOW = 2'b10
	} ltirq_cmp_type;

endpackage

// *** ltirq_fault_run.sv ***
// consecutive fault counter that qualifies high and low comparisons
`timescale 1ns/1ns
`default_nettype none
module ltirq_fault_run (
	input wire logic clk,
	input wire logic rst,
	input wire logic conv_done,
	input wire ltirq_pkg::ltirq_cmp_type cmp,
	input wire logic [1:0] fc_code,
	output logic hit_high,
	output logic hit_low
);
	ltirq_pkg::ltirq_cmp_type outcome_q;
	ltirq_pkg::ltirq_cmp_type outcome_d;
	logic [2:0] run_q;
	logic [2:0] run_d;
	logic [2:0] target;

	// run length per outcome; a different outcome restarts the run
	always_comb begin
		outcome_d = outcome_q;
		run_d = run_q;
		target = {1'b0, fc_code} + 3'h1;
		if (conv_done) begin
			if (cmp != outcome_q) begin
				outcome_d = cmp;
				run_d = 3'h1;
			end else if (run_q != ltirq_pkg::RUN_SAT) begin
				run_d = run_q + 3'h1;
			end
		end
		// qualified once the run reaches the programmed length
		hit_high = conv_done && cmp == ltirq_pkg::LTIRQ_CMP_HIGH && run_d >= target;
		hit_low = conv_done && cmp == ltirq_pkg::LTIRQ_CMP_LOW && run_d >= target;
	end

	// run state registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			outcome_q <= ltirq_pkg::LTIRQ_CMP_NONE;
			run_q <= 3'h0;
		end else begin
			outcome_q <= outcome_d;
			run_q <= run_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_no_early_hit;
		conv_done && fc_code != 2'h0 && cmp != outcome_q |-> !hit_high && !hit_low;
	endproperty
	a_no_early_hit: assert property (p_no_early_hit) else $error("hit before run complete");
endmodule
`default_nettype wire

// *** ltirq_od_pin.sv ***
// open-drain interrupt pin driver with selectable level
`timescale 1ns/1ns
`default_nettype none
module ltirq_od_pin (
	input wire logic clk,
	input wire logic rst,
	input wire logic irq_active,
	input wire logic level_sel,
	output logic pin_o,
	output logic pin_oe
);
	logic oe_q;
	logic oe_d;
	logic o_q;

	// pull low when active with level 0, or inactive with level 1
	always_comb begin
		oe_d = irq_active ^ level_sel;
	end

	// the pin only ever pulls low; the data flop stays at zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oe_q <= 1'b0;
			o_q <= 1'b0;
		end else begin
			oe_q <= oe_d;
			o_q <= 1'b0;
		end
	end

	assign pin_o = o_q;
	assign pin_oe = oe_q;
endmodule
`default_nettype wire

// *** ltirq_top.sv ***
// interrupt reporting core: limits, flags, ready bit and interrupt pin
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - latched mode, qualified high fault sets flag-high, interrupt and ready.
// - latched mode, qualified low fault sets flag-low, interrupt and ready.
// - unqualified conversion only sets ready, outside end-of-conversion mode.
// - latched mode, config read clears both flags and the interrupt.
// - config read clears ready; first read after completion sees 1.
// - config write selecting shutdown changes no reporting state, except in latched mode a latch bit of 0 drops the interrupt.
// - config write not shutdown clears ready; comparison state kept.
// - latched mode, alert response drops interrupt, keeps flags and ready.
// - transparent mode, high fault: interrupt on, flag-high 1, flag-low 0.
// - transparent mode, low fault: interrupt off outside end-of-conversion mode, flag-low 1, flag-high 0.
// - transparent mode, config reads and writes leave flags, and the interrupt outside end-of-conversion mode.
// - with latch bit 0 the alert response is ignored completely.
// - pin pulls low when active xor level select is one.
// - low-limit top bits 11 select end-of-conversion mode.
// - end-of-conversion mode asserts interrupt on every completion.
// - end-of-conversion interrupt cleared by read, non-shutdown write, and alert in latched mode.
// - end-of-conversion plus latched keeps latched flag setting and read clear.
// - a fault reports only after the programmed consecutive count.
// - latch bit 4 of config: 1 latched window, 0 transparent.
module ltirq_top (
	input wire logic clk,
	input wire logic rst,
	input wire ltirq_pkg::ltirq_req_type req,
	output logic [15:0] rd_data,
	input wire logic conv_done,
	input wire logic [15:0] conv_result,
	input wire logic alert_resp,
	output logic alert_ack,
	input wire logic int_i,
	output logic int_o,
	output logic int_oe
);
	// ****************************************
	// register state
	// ****************************************
	logic latch_q;
	logic latch_d;
	logic level_q;
	logic level_d;
	logic [1:0] fc_q;
	logic [1:0] fc_d;
	logic [1:0] mode_q;
	logic [1:0] mode_d;
	logic [15:0] low_q;
	logic [15:0] low_d;
	logic [15:0] high_q;
	logic [15:0] high_d;
	logic [15:0] result_q;
	logic [15:0] result_d;
	logic fh_q;
	logic fh_d;
	logic fl_q;
	logic fl_d;
	logic act_q;
	logic act_d;
	logic rdy_q;
	logic rdy_d;
	logic ack_q;
	logic ack_d;
	logic [15:0] rd_q;
	logic [15:0] rd_d;
	logic pin_in_q;

	logic rd_cfg;
	logic wr_cfg;
	logic wr_run;
	logic eoc;
	logic hit_high;
	logic hit_low;
	ltirq_pkg::ltirq_cmp_type cmp;

	// ****************************************
	// decode and comparison
	// ****************************************

	// config accesses and mode selection
	assign rd_cfg = req.rd && req.addr == ltirq_pkg::ADDR_CFG;
	assign wr_cfg = req.wr && req.addr == ltirq_pkg::ADDR_CFG;
	assign wr_run = wr_cfg && req.wdata[ltirq_pkg::CFG_MODE_LSB +: 2] != ltirq_pkg::MODE_SHUTDOWN;
	assign eoc = low_q[ltirq_pkg::LOW_TOP_LSB +: 2] == ltirq_pkg::EOC_CODE;

	// raw unsigned compare; a high limit below the low limit is the host's problem
	always_comb begin
		if (conv_result > high_q) begin
			cmp = ltirq_pkg::LTIRQ_CMP_HIGH;
		end else if (conv_result < low_q) begin
			cmp = ltirq_pkg::LTIRQ_CMP_LOW;
		end else begin
			cmp = ltirq_pkg::LTIRQ_CMP_NONE;
		end
	end

	ltirq_fault_run u_run (
		.clk(clk),
		.rst(rst),
		.conv_done(conv_done),
		.cmp(cmp),
		.fc_code(fc_q),
		.hit_high(hit_high),
		.hit_low(hit_low)
	);

	// ****************************************
	// software registers
	// ****************************************

	// writable fields; flags and ready are read-only to software
	always_comb begin
		latch_d = latch_q;
		level_d = level_q;
		fc_d = fc_q;
		mode_d = mode_q;
		low_d = low_q;
		high_d = high_q;
		result_d = result_q;
		if (wr_cfg) begin
			latch_d = req.wdata[ltirq_pkg::CFG_LATCH];
			level_d = req.wdata[ltirq_pkg::CFG_LEVEL];
			fc_d = req.wdata[ltirq_pkg::CFG_FC_LSB +: 2];
			mode_d = req.wdata[ltirq_pkg::CFG_MODE_LSB +: 2];
		end
		if (req.wr && req.addr == ltirq_pkg::ADDR_LOW) begin
			low_d = req.wdata;
		end
		if (req.wr && req.addr == ltirq_pkg::ADDR_HIGH) begin
			high_d = req.wdata;
		end
		if (conv_done) begin
			result_d = conv_result;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_q <= ltirq_pkg::LATCH_RST;
			level_q <= ltirq_pkg::LEVEL_RST;
			fc_q <= ltirq_pkg::FC_RST;
			mode_q <= ltirq_pkg::MODE_RST;
			low_q <= ltirq_pkg::LOW_RST;
			high_q <= ltirq_pkg::HIGH_RST;
			result_q <= ltirq_pkg::RESULT_RST;
		end else begin
			latch_q <= latch_d;
			level_q <= level_d;
			fc_q <= fc_d;
			mode_q <= mode_d;
			low_q <= low_d;
			high_q <= high_d;
			result_q <= result_d;
		end
	end

	// ****************************************
	// reporting state
	// ****************************************

	// clears are applied first so that a same-cycle set always wins
	always_comb begin
		fh_d = fh_q;
		fl_d = fl_q;
		act_d = act_q;
		rdy_d = rdy_q;
		ack_d = 1'b0;
		if (latch_q) begin
			if (rd_cfg) begin
				fh_d = 1'b0;
				fl_d = 1'b0;
				act_d = 1'b0;
			end
			if (alert_resp) begin
				ack_d = act_q;
				act_d = 1'b0;
			end
			// dropping the latch bit releases a stale latched interrupt
			if (wr_cfg && !req.wdata[ltirq_pkg::CFG_LATCH]) begin
				act_d = 1'b0;
			end
			if (hit_high) begin
				fh_d = 1'b1;
				act_d = 1'b1;
			end
			if (hit_low) begin
				fl_d = 1'b1;
				act_d = 1'b1;
			end
		end else begin
			// transparent: only qualified comparisons move state, alert unseen
			if (hit_high) begin
				fh_d = 1'b1;
				fl_d = 1'b0;
				act_d = 1'b1;
			end
			if (hit_low) begin
				fl_d = 1'b1;
				fh_d = 1'b0;
				act_d = 1'b0;
			end
		end
		// end of conversion overrides the comparison on the pin state
		if (eoc) begin
			if (rd_cfg || wr_run) begin
				act_d = 1'b0;
			end
			if (conv_done) begin
				act_d = 1'b1;
			end
		end
		// shutdown writes skip the ready and end-of-conversion clears; only the latch-drop clear above sees them
		if (rd_cfg || wr_run) begin
			rdy_d = 1'b0;
		end
		if (conv_done) begin
			rdy_d = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fh_q <= 1'b0;
			fl_q <= 1'b0;
			act_q <= 1'b0;
			rdy_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			fh_q <= fh_d;
			fl_q <= fl_d;
			act_q <= act_d;
			rdy_q <= rdy_d;
			ack_q <= ack_d;
		end
	end

	// ****************************************
	// read data and pin
	// ****************************************

	// read data shows the state before the read's own clearing effect
	always_comb begin
		rd_d = 16'h0000;
		if (req.rd) begin
			unique case (req.addr)
				ltirq_pkg::ADDR_RESULT: rd_d = result_q;
				ltirq_pkg::ADDR_CFG: begin
					rd_d[ltirq_pkg::CFG_FC_LSB +: 2] = fc_q;
					rd_d[ltirq_pkg::CFG_LEVEL] = level_q;
					rd_d[ltirq_pkg::CFG_LATCH] = latch_q;
					rd_d[ltirq_pkg::CFG_FLAG_LOW] = fl_q;
					rd_d[ltirq_pkg::CFG_FLAG_HIGH] = fh_q;
					rd_d[ltirq_pkg::CFG_READY] = rdy_q;
					rd_d[ltirq_pkg::CFG_MODE_LSB +: 2] = mode_q;
				end
				ltirq_pkg::ADDR_LOW: rd_d = low_q;
				ltirq_pkg::ADDR_HIGH: rd_d = high_q;
				ltirq_pkg::ADDR_STAT: begin
					rd_d[ltirq_pkg::STAT_PIN] = pin_in_q;
					rd_d[ltirq_pkg::STAT_ACTIVE] = act_q;
				end
				default: rd_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_q <= 16'h0000;
			pin_in_q <= 1'b1;
		end else begin
			rd_q <= rd_d;
			pin_in_q <= int_i;
		end
	end

	assign rd_data = rd_q;
	assign alert_ack = ack_q;

	ltirq_od_pin u_pin (
		.clk(clk),
		.rst(rst),
		.irq_active(act_q),
		.level_sel(level_q),
		.pin_o(int_o),
		.pin_oe(int_oe)
	);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_rdy_clear;
		rd_cfg && !conv_done ##1 rd_cfg |=> rd_data[ltirq_pkg::CFG_READY] == 1'b0;
	endproperty
	a_rdy_clear: assert property (p_rdy_clear) else $error("second read saw ready");
	property p_shutdown_hold;
		wr_cfg && !wr_run && !conv_done |=> $stable(rdy_q) && $stable(fh_q) && $stable(act_q);
	endproperty
	a_shutdown_hold: assert property (p_shutdown_hold) else $error("shutdown write moved state");
	property p_latch_read;
		latch_q && rd_cfg && !conv_done |=> !fh_q && !fl_q && !act_q;
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("latched read did not clear");
	property p_alert_keep;
		latch_q && alert_resp && !conv_done |=> !act_q && $stable(fh_q) && $stable(rdy_q);
	endproperty
	a_alert_keep: assert property (p_alert_keep) else $error("alert response misbehaved");
	property p_trans_high;
		!latch_q && hit_high |=> fh_q && !fl_q && act_q;
	endproperty
	a_trans_high: assert property (p_trans_high) else $error("transparent high wrong");
	property p_trans_low;
		!latch_q && !eoc && hit_low |=> fl_q && !fh_q && !act_q;
	endproperty
	a_trans_low: assert property (p_trans_low) else $error("transparent low wrong");
	property p_trans_access;
		!latch_q && (req.rd || req.wr) && !conv_done |=> $stable(fh_q) && $stable(fl_q);
	endproperty
	a_trans_access: assert property (p_trans_access) else $error("access moved flags");
	property p_no_ack;
		!latch_q && alert_resp |=> !alert_ack;
	endproperty
	a_no_ack: assert property (p_no_ack) else $error("alert answered in transparent");
	property p_eoc_every;
		eoc && conv_done |=> act_q ##1 int_oe == !level_q;
	endproperty
	a_eoc_every: assert property (p_eoc_every) else $error("no interrupt at completion");
	property p_pin;
		1'b1 |=> int_oe == $past(act_q ^ level_q);
	endproperty
	a_pin: assert property (p_pin) else $error("pin drive wrong");
endmodule
`default_nettype wire

// *** ltirq_line_model.sv ***
// pulled-up interrupt line shared by the host and the reporting block
`timescale 1ns/1ns
`default_nettype none
module ltirq_line_model (
	input wire logic int_o,
	input wire logic int_oe,
	output logic line
);
	// ****************************************
	// wire level
	// ****************************************
	// the pull-up wins whenever nobody pulls, so a released pin never reads as the last value
	assign line = int_oe ? int_o : 1'h1;
endmodule
`default_nettype wire

// *** test_light_threshold_irq_reporting.sv ***
// self-checking bench for the interrupt reporting core, acting as host
`timescale 1ns/1ns
`default_nettype none
module test_light_threshold_irq_reporting;
	logic clk;
	logic rst;
	ltirq_pkg::ltirq_req_type req;
	logic [15:0] rd_data;
	logic conv_done;
	logic [15:0] conv_result;
	logic alert_resp;
	logic alert_ack;
	logic int_o;
	logic int_oe;
	logic line;
	int n_fail;
	int compares;
	int cycles;

	// ****************************************
	// design and line
	// ****************************************
	ltirq_top u_ltirq_top (.clk(clk), .rst(rst), .req(req), .rd_data(rd_data),
		.conv_done(conv_done), .conv_result(conv_result), .alert_resp(alert_resp),
		.alert_ack(alert_ack), .int_i(line), .int_o(int_o), .int_oe(int_oe));
	ltirq_line_model u_ltirq_line_model (.int_o(int_o), .int_oe(int_oe), .line(line));

	// ****************************************
	// clock and hang guard
	// ****************************************
	// free-running clock at 20 ns
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	// a stuck handshake would stall the run, so cut it off well past the expected length
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			n_fail = n_fail + 1;
			end_of_test();
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'h1;
		@(posedge clk);
		req.wr <= 1'h0;
	endtask
	// read data stand only in the cycle after the strobe, so look just after that edge
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'h1;
		@(posedge clk);
		req.rd <= 1'h0;
		#1;
		chk(rd_data, e);
	endtask
	// two reads with no gap: the strobe stays high across two edges
	task automatic rd_pair(input logic [3:0] a, input logic [15:0] e1, input logic [15:0] e2);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'h1;
		@(posedge clk);
		#1;
		chk(rd_data, e1);
		@(posedge clk);
		req.rd <= 1'h0;
		#1;
		chk(rd_data, e2);
	endtask
	task automatic conv(input logic [15:0] r);
		@(posedge clk);
		conv_done <= 1'h1;
		conv_result <= r;
		@(posedge clk);
		conv_done <= 1'h0;
	endtask
	task automatic alert(input logic e);
		@(posedge clk);
		alert_resp <= 1'h1;
		@(posedge clk);
		alert_resp <= 1'h0;
		#1;
		chk({15'h0000, alert_ack}, {15'h0000, e});
	endtask
	// pin follows the state one cycle later, so wait an edge first
	task automatic pin(input logic e);
		@(posedge clk);
		#1;
		chk({15'h0000, line}, {15'h0000, e});
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	// limits: low 0100, high 1000; config base = fault code 1, latch, mode 01
	initial begin
		rst = 1'h1;
		req = '0;
		conv_done = 1'h0;
		conv_result = 16'h0000;
		alert_resp = 1'h0;
		n_fail = 0;
		compares = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		rd(ltirq_pkg::ADDR_CFG, 16'h0010);
		rd(ltirq_pkg::ADDR_HIGH, 16'hffff);
		rd(4'h5, 16'h0000);
		pin(1'h1);
		$display("reset values done");
		wr(ltirq_pkg::ADDR_LOW, 16'h0100);
		wr(ltirq_pkg::ADDR_HIGH, 16'h1000);
		wr(ltirq_pkg::ADDR_CFG, 16'h0211);
		conv(16'h2000);
		rd(ltirq_pkg::ADDR_CFG, 16'h0291);
		pin(1'h1);
		conv(16'h2000);
		pin(1'h0);
		rd(ltirq_pkg::ADDR_STAT, 16'h0002);
		alert(1'h1);
		pin(1'h1);
		rd_pair(ltirq_pkg::ADDR_CFG, 16'h02d1, 16'h0211);
		conv(16'h0010);
		conv(16'h0500);
		conv(16'h0010);
		rd(ltirq_pkg::ADDR_STAT, 16'h0001);
		conv(16'h0010);
		pin(1'h0);
		wr(ltirq_pkg::ADDR_CFG, 16'h0011);
		pin(1'h0);
		wr(ltirq_pkg::ADDR_CFG, 16'h0211);
		pin(1'h0);
		rd(ltirq_pkg::ADDR_CFG, 16'h0231);
		pin(1'h1);
		wr(ltirq_pkg::ADDR_CFG, 16'h0219);
		pin(1'h0);
		$display("latched window test done");
		wr(ltirq_pkg::ADDR_CFG, 16'h0201);
		conv(16'h2000);
		conv(16'h2000);
		pin(1'h0);
		rd(ltirq_pkg::ADDR_CFG, 16'h02c1);
		rd(ltirq_pkg::ADDR_CFG, 16'h0241);
		alert(1'h0);
		pin(1'h0);
		conv(16'h0010);
		conv(16'h0010);
		pin(1'h1);
		rd(ltirq_pkg::ADDR_CFG, 16'h02a1);
		$display("transparent test done");
		wr(ltirq_pkg::ADDR_CFG, 16'h0211);
		wr(ltirq_pkg::ADDR_HIGH, 16'hf000);
		wr(ltirq_pkg::ADDR_LOW, 16'hc100);
		conv(16'hd000);
		pin(1'h0);
		rd(ltirq_pkg::ADDR_CFG, 16'h02b1);
		pin(1'h1);
		conv(16'hd000);
		pin(1'h0);
		wr(ltirq_pkg::ADDR_CFG, 16'h0211);
		pin(1'h1);
		conv(16'hd000);
		alert(1'h1);
		pin(1'h1);
		conv(16'hf800);
		conv(16'hf800);
		rd(ltirq_pkg::ADDR_CFG, 16'h02d1);
		rd(ltirq_pkg::ADDR_CFG, 16'h0211);
		conv(16'hd000);
		pin(1'h0);
		wr(ltirq_pkg::ADDR_LOW, 16'h0100);
		wr(ltirq_pkg::ADDR_CFG, 16'h0201);
		pin(1'h1);
		wr(ltirq_pkg::ADDR_CFG, 16'h0211);
		pin(1'h1);
		$display("end-of-conversion test done");
		// fault code 0 reports on the first fault, code 3 only on the fourth in a row
		wr(ltirq_pkg::ADDR_CFG, 16'h0210);
		conv(16'hf800);
		pin(1'h0);
		rd(ltirq_pkg::ADDR_CFG, 16'h02d0);
		wr(ltirq_pkg::ADDR_CFG, 16'h0213);
		repeat (3) conv(16'h0010);
		pin(1'h1);
		conv(16'h0010);
		pin(1'h0);
		rd(ltirq_pkg::ADDR_CFG, 16'h02b3);
		$display("fault count test done");
		// a second reset in mid-run must bring back the reset values
		@(posedge clk);
		rst <= 1'h1;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		rd(ltirq_pkg::ADDR_CFG, 16'h0010);
		rd(ltirq_pkg::ADDR_LOW, 16'h0000);
		pin(1'h1);
		$display("reset recovery done");
		end_of_test();
	end
endmodule
`default_nettype wire
